// ### logic/wwd_map.vh
// register offsets, option-byte fields and codes of the windowed watchdog
// included by the watchdog core, its monitor and the bench; definitions only
`ifndef WWD_MAP_VH
`define WWD_MAP_VH

// ==========================================================
// addresses
`define WWD_OPTION_BYTE_ADDR 16'h0080
`define WWD_RESTART_REG_ADDR 16'hFF99
`define WWD_TOP_REGION_BASE 16'hFB00

// ==========================================================
// option byte fields
`define WWD_OPT_SPAN_HI 6
`define WWD_OPT_SPAN_LO 5
`define WWD_OPT_ENABLE 4
`define WWD_OPT_TSEL_HI 3
`define WWD_OPT_TSEL_LO 1
`define WWD_OPT_OSC_LOCK 0

// ==========================================================
// restart register codes and reset values
`define WWD_RESTART_CODE 8'hAC
`define WWD_RESTART_RST_ON 8'h9A
`define WWD_RESTART_RST_OFF 8'h1A

// ==========================================================
// counter sizing
`define WWD_CNT_W 17
`define WWD_TIMEOUT_BASE_EXP 10

`endif

// ### logic/wwd_slow_counter.v
// up counter on the slow oscillator clock, with clear and freeze
// assumes clear and run arrive synchronised to the slow clock
`timescale 1ns/1ps

module wwd_slow_counter
(
    // clock and reset
    input wire slow_clk_i,
    input wire resetn_i,
    // control
    input wire run_i,
    input wire clear_i,
    // count
    output reg [16:0] count_o
);

// ==========================================================
// counter
always @(posedge slow_clk_i or negedge resetn_i)
begin
    if (!resetn_i)
        count_o <= 17'h00000;
    else if (clear_i)
        count_o <= 17'h00000;
    else if (run_i)
        count_o <= count_o + 17'h00001;
end

endmodule // wwd_slow_counter

// ### logic/wwd_watchdog.v
// windowed watchdog core: restart register, window check, overflow,
// illegal access detection, reset request and reset-cause flag
// assumes bus strobes synchronous to core_clk_i; the slow clock is sampled,
// and clocks the clear and run synchronisers and the counter module
//
// Function
// - counter advances only on the slow oscillator clock
// - counter reaching selected timeout raises reset request
// - writing the restart code clears the counter to zero
// - any other value written to restart register raises reset
// - single-bit access to restart register raises reset
// - illegal access while slow clock stopped waits for clock to resume
// - restart register reads return reset-time value only
// - restart register resets to 1A when disabled, 9A when enabled
// - enable option starts counting and illegal access detection
// - 3-bit field picks timeout of 2^(10+n) slow periods
// - 2-bit field sets share of period forming open window
// - window codes give 25, 50, 75, 100 percent, final portion
// - restart in closed window raises reset instead of clearing
// - first restart after reset clears regardless of window
// - restart-to-overflow may differ by two slow periods
// - restart in last count before overflow still honoured
// - lock option 0 freezes counter in halt and stop
// - lock 0 with oscillator halted stops counter, keeps value
// - fetch outside region, or data access between region and top region, raises reset
// - any watchdog reset sets the reset-cause flag
`timescale 1ns/1ps
`include "wwd_map.vh"

module wwd_watchdog
(
    // clocks and reset
    input wire core_clk_i,
    input wire resetn_i,
    input wire slow_clk_i,
    // option byte and low-power state
    input wire [7:0] option_byte_i,
    input wire halt_mode_i,
    input wire stop_mode_i,
    input wire slow_osc_halt_bit_i,
    // restart register access
    input wire [15:0] bus_addr_i,
    input wire bus_wr_i,
    input wire bus_rd_i,
    input wire bus_bit_op_i,
    input wire [7:0] bus_wdata_i,
    output reg [7:0] bus_rdata_o,
    // memory region checking
    input wire fetch_i,
    input wire [15:0] fetch_addr_i,
    input wire data_acc_i,
    input wire [15:0] region_limit_i,
    // reset outputs
    output reg reset_req_o,
    output reg dog_reset_cause_flag_o,
    input wire cause_clear_i
);

// ==========================================================
// option fields
wire counter_enable_opt = option_byte_i[`WWD_OPT_ENABLE];
wire slow_osc_lock_opt = option_byte_i[`WWD_OPT_OSC_LOCK];
wire [2:0] timeout_sel =
    option_byte_i[`WWD_OPT_TSEL_HI:`WWD_OPT_TSEL_LO];
wire [1:0] open_span_sel =
    option_byte_i[`WWD_OPT_SPAN_HI:`WWD_OPT_SPAN_LO];

// timeout in slow periods minus one
function [16:0] limit_of;
    input [2:0] sel;
    begin
        limit_of = (17'h00001 << (`WWD_TIMEOUT_BASE_EXP + sel))
            - 17'h00001;
    end
endfunction

// address match of a bus access
function addr_is;
    input [15:0] addr;
    input [15:0] target;
    begin
        addr_is = addr == target;
    end
endfunction

// first count of the open window: timeout scaled by closed share
// shortest timeout with the 25 percent window leaves too little open
// time; the option byte must never pair the two
function [16:0] open_start_of;
    input [2:0] sel;
    input [1:0] span;
    reg [17:0] tmo;
    begin
        tmo = 18'h00001 << (`WWD_TIMEOUT_BASE_EXP + sel);
        case (span)
            2'h0: open_start_of = tmo[16:0] - {1'b0, tmo[17:2]};
            2'h1: open_start_of = tmo[17:1];
            2'h2: open_start_of = {1'b0, tmo[17:2]};
            default: open_start_of = 17'h00000;
        endcase
    end
endfunction

// ==========================================================
// enable latched after reset release
reg enabled_q;
reg started_q;
always @(posedge core_clk_i or negedge resetn_i)
begin
    if (!resetn_i)
    begin
        enabled_q <= 1'b0;
        started_q <= 1'b0;
    end
    else if (!started_q)
    begin
        enabled_q <= counter_enable_opt;
        started_q <= 1'b1;
    end
end

// ==========================================================
// slow clock sampling for activity detection
reg slow_s1_q;
reg slow_s2_q;
reg slow_s3_q;
always @(posedge core_clk_i or negedge resetn_i)
begin
    if (!resetn_i)
    begin
        slow_s1_q <= 1'b0;
        slow_s2_q <= 1'b0;
        slow_s3_q <= 1'b0;
    end
    else
    begin
        slow_s1_q <= slow_clk_i;
        slow_s2_q <= slow_s1_q;
        slow_s3_q <= slow_s2_q;
    end
end
wire slow_edge = slow_s2_q & ~slow_s3_q;

// oscillator is stopped when lock is off and software halts it
wire osc_stopped = !slow_osc_lock_opt & slow_osc_halt_bit_i;
wire freeze = !slow_osc_lock_opt & (halt_mode_i | stop_mode_i);

// ==========================================================
// restart register access decode
wire hit = addr_is(bus_addr_i, `WWD_RESTART_REG_ADDR);
wire wr_hit = bus_wr_i & hit;
wire good_code = bus_wdata_i == `WWD_RESTART_CODE;

// clear request toggled into slow domain; count read back safely
reg clr_tgl_q;
reg [1:0] clr_sync_q;
reg clr_seen_q;
wire [16:0] count;
reg [16:0] cnt_a_q;
reg [16:0] cnt_b_q;
reg first_done_q;
reg pend_q;

wire [16:0] limit = limit_of(timeout_sel);
wire in_open = cnt_b_q >= open_start_of(timeout_sel, open_span_sel);
wire clr_in_flight = clr_tgl_q != clr_seen_q;

// ==========================================================
// events and pending illegal access
wire bad_write = wr_hit & (bus_bit_op_i | !good_code);
wire bad_window = wr_hit & !bus_bit_op_i & good_code & first_done_q
    & !in_open & !clr_in_flight;
wire outside = (fetch_i & (fetch_addr_i > region_limit_i))
    | (data_acc_i & (fetch_addr_i > region_limit_i)
    & (fetch_addr_i < `WWD_TOP_REGION_BASE));
wire overflow = enabled_q & (cnt_b_q == limit) & !clr_in_flight;
// restart accepted: full write of the code outside the closed window, or any full write of it before the first restart or while a clear is in flight
wire good_restart = wr_hit & !bus_bit_op_i & good_code & !bad_window;

// ==========================================================
// restart toggle and first-restart marker
always @(posedge core_clk_i or negedge resetn_i)
begin
    if (!resetn_i)
    begin
        clr_tgl_q <= 1'b0;
        first_done_q <= 1'b0;
    end
    else if (good_restart)
    begin
        clr_tgl_q <= ~clr_tgl_q;
        first_done_q <= 1'b1;
    end
end

// ==========================================================
// illegal access remembered until the slow clock runs
always @(posedge core_clk_i or negedge resetn_i)
begin
    if (!resetn_i)
        pend_q <= 1'b0;
    else if (enabled_q & (bad_write | bad_window | outside))
        pend_q <= 1'b1;
end

// ==========================================================
// sticky reset request; a pending illegal access waits for slow clock activity
always @(posedge core_clk_i or negedge resetn_i)
begin
    if (!resetn_i)
        reset_req_o <= 1'b0;
    else if (enabled_q & ((pend_q & !osc_stopped & slow_edge)
        | overflow))
        reset_req_o <= 1'b1;
end

// ==========================================================
// clear crossing into slow domain; sent as a toggle so that a
// one-cycle core strobe is not lost between two slow edges
always @(posedge slow_clk_i or negedge resetn_i)
begin
    if (!resetn_i)
    begin
        clr_sync_q <= 2'h0;
    end
    else
    begin
        clr_sync_q <= {clr_sync_q[0], clr_tgl_q};
    end
end
reg clr_last_q;
always @(posedge slow_clk_i or negedge resetn_i)
begin
    if (!resetn_i)
        clr_last_q <= 1'b0;
    else
        clr_last_q <= clr_sync_q[1];
end
wire slow_clear = clr_sync_q[1] ^ clr_last_q;

// ==========================================================
// run enable carried into the slow domain through two flops
wire run_core = enabled_q & !freeze & !osc_stopped;
reg [1:0] run_sync_q;
always @(posedge slow_clk_i or negedge resetn_i)
begin
    if (!resetn_i)
        run_sync_q <= 2'h0;
    else
        run_sync_q <= {run_sync_q[0], run_core};
end

wwd_slow_counter u_counter
(
    .slow_clk_i(slow_clk_i),
    .resetn_i(resetn_i),
    .run_i(run_sync_q[1]),
    .clear_i(slow_clear),
    .count_o(count)
);

// ==========================================================
// count read back: sampled twice, accepted when stable, so a word
// caught mid-increment never reaches the window or overflow compare
always @(posedge core_clk_i or negedge resetn_i)
begin
    if (!resetn_i)
    begin
        cnt_a_q <= 17'h00000;
        cnt_b_q <= 17'h00000;
        clr_seen_q <= 1'b0;
    end
    else
    begin
        cnt_a_q <= count;
        if (cnt_a_q == count)
            cnt_b_q <= cnt_a_q;
        if (slow_edge)
            clr_seen_q <= clr_last_q;
    end
end

// ==========================================================
// read data and reset cause
always @(posedge core_clk_i or negedge resetn_i)
begin
    if (!resetn_i)
    begin
        bus_rdata_o <= 8'h00;
        dog_reset_cause_flag_o <= 1'b0;
    end
    else
    begin
        if (bus_rd_i & hit)
            bus_rdata_o <= enabled_q ? `WWD_RESTART_RST_ON
                : `WWD_RESTART_RST_OFF;
        else if (bus_rd_i & addr_is(bus_addr_i, `WWD_OPTION_BYTE_ADDR))
            bus_rdata_o <= option_byte_i;
        else if (bus_rd_i)
            bus_rdata_o <= 8'h00;
        if (reset_req_o)
            dog_reset_cause_flag_o <= 1'b1;
        else if (cause_clear_i)
            dog_reset_cause_flag_o <= 1'b0;
    end
end

endmodule // wwd_watchdog

// ### testbench/wwd_monitor.sv
// port checker of the windowed watchdog core
// bound into every core instance; strobes are one core cycle wide
`timescale 1ns/1ps
`include "wwd_map.vh"

module wwd_monitor
(
    // clock and reset
    input wire core_clk_i,
    input wire resetn_i,
    // inputs
    input wire [7:0] option_byte_i,
    input wire [15:0] bus_addr_i,
    input wire bus_wr_i,
    input wire bus_rd_i,
    input wire bus_bit_op_i,
    input wire [7:0] bus_wdata_i,
    input wire fetch_i,
    input wire [15:0] fetch_addr_i,
    input wire [15:0] region_limit_i,
    input wire slow_osc_halt_bit_i,
    // outputs
    input wire [7:0] bus_rdata_o,
    input wire reset_req_o,
    input wire dog_reset_cause_flag_o
);
    // ====
    // properties
    wire en = option_byte_i[4];
    wire hit = bus_addr_i == `WWD_RESTART_REG_ADDR;
    // a stopped oscillator delays illegal-access resets
    wire wr = en && bus_wr_i && hit && !slow_osc_halt_bit_i;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    req_sticky_a: assert property (reset_req_o |=> reset_req_o)
        else $error("reset request dropped");
    cause_set_a: assert property (reset_req_o
        |=> dog_reset_cause_flag_o) else $error("cause flag not set");
    read_on_a: assert property (en && bus_rd_i && hit
        |=> bus_rdata_o == `WWD_RESTART_RST_ON) else $error("bad read");
    read_off_a: assert property (!en && bus_rd_i && hit
        |=> bus_rdata_o == `WWD_RESTART_RST_OFF) else $error("bad read");
    bad_code_a: assert property (wr
        && bus_wdata_i != `WWD_RESTART_CODE
        |-> ##[1:40] reset_req_o) else $error("bad code missed");
    bit_op_a: assert property (wr && bus_bit_op_i
        |-> ##[1:40] reset_req_o) else $error("bit access missed");
    off_quiet_a: assert property (!en |-> !reset_req_o)
        else $error("reset while disabled");
    fetch_out_a: assert property (en && fetch_i
        && !slow_osc_halt_bit_i && fetch_addr_i > region_limit_i
        |-> ##[1:40] reset_req_o)
        else $error("bad fetch missed");
endmodule // wwd_monitor

bind wwd_watchdog wwd_monitor mon
(
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .option_byte_i(option_byte_i),
    .bus_addr_i(bus_addr_i),
    .bus_wr_i(bus_wr_i),
    .bus_rd_i(bus_rd_i),
    .bus_bit_op_i(bus_bit_op_i),
    .bus_wdata_i(bus_wdata_i),
    .fetch_i(fetch_i),
    .fetch_addr_i(fetch_addr_i),
    .region_limit_i(region_limit_i),
    .slow_osc_halt_bit_i(slow_osc_halt_bit_i),
    .bus_rdata_o(bus_rdata_o),
    .reset_req_o(reset_req_o),
    .dog_reset_cause_flag_o(dog_reset_cause_flag_o)
);

// ### testbench/wwd_osc_model.sv
// slow oscillator and system reset sink beside the core
// clock runs unless stop_i holds it, phase unrelated to the core clock
`timescale 1ns/1ps

module wwd_osc_model
(
    // reset request and oscillator stop in
    input wire reset_req_i,
    input wire stop_i,
    // slow clock and seen flag out
    output reg slow_clk_o,
    output reg seen_o
);
    // ====
    // behaviour
    initial slow_clk_o = 1'b0;
    initial seen_o = 1'b0;
    always #43 if (!stop_i) slow_clk_o = ~slow_clk_o;
    always @(posedge reset_req_i) seen_o = 1'b1;
endmodule // wwd_osc_model

// ### testbench/windowed_watchdog_timer_tb.sv
// self-checking bench of the windowed watchdog core
// assumes the oscillator model gives an 86 ns slow clock
`timescale 1ns/1ps
`include "wwd_map.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
    n_mismatch++; $display("ERROR %0t got %h exp %h", $time, a, b); end end

module windowed_watchdog_timer_tb;
    // ====
    // signals and design
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg halt = 1'b0;
    reg stopm = 1'b0;
    reg ostop = 1'b0;
    reg [7:0] opt = 8'h00;
    reg [4:0] stb = 5'h00;
    reg [15:0] addr = 16'h0000;
    reg [7:0] wd = 8'h00;
    reg [7:0] d;
    wire [7:0] rdata;
    wire req, flag, slow, seen;
    int n_mismatch = 0;
    int total_checks = 0;
    localparam [15:0] WA = `WWD_RESTART_REG_ADDR;
    localparam [7:0] AC = `WWD_RESTART_CODE;
    always #5 clk = ~clk;
    wwd_osc_model osc (.reset_req_i(req), .stop_i(ostop),
        .slow_clk_o(slow), .seen_o(seen));
    wwd_watchdog uut
    (
        .core_clk_i(clk), .resetn_i(rstn), .slow_clk_i(slow),
        .option_byte_i(opt), .halt_mode_i(halt), .stop_mode_i(stopm),
        .slow_osc_halt_bit_i(ostop), .bus_addr_i(addr), .bus_wr_i(stb[0]),
        .bus_rd_i(stb[1]), .bus_bit_op_i(stb[2]), .bus_wdata_i(wd),
        .bus_rdata_o(rdata), .fetch_i(stb[3]), .fetch_addr_i(addr),
        .data_acc_i(stb[4]), .region_limit_i(16'h7FFF),
        .reset_req_o(req), .dog_reset_cause_flag_o(flag),
        .cause_clear_i(1'b0)
    );
    // ====
    // helpers
    function int tmo(input [2:0] s);
        return (1 << (10 + s)) * 86 / 10;
    endfunction
    function [7:0] exp_rd(input [7:0] o);
        return o[4] ? `WWD_RESTART_RST_ON : `WWD_RESTART_RST_OFF;
    endfunction
    task boot(input [7:0] o);
        @(posedge clk);
        rstn <= 1'b0;
        opt <= o;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task op(input [4:0] k, input [15:0] a, input [7:0] v);
        @(posedge clk);
        stb <= k;
        addr <= a;
        wd <= v;
        @(posedge clk);
        stb <= 5'h00;
        @(negedge clk);
    endtask
    task wait_req(input int n);
        for (int j = 0; j < n; j++)
        begin
            @(negedge clk);
            if (req === 1'b1)
                break;
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        #700000;
        n_mismatch++;
        stop_test;
    end
    // ====
    // tests
    initial
    begin
        void'($urandom(7889));
        for (int r = 0; r < 4; r++)
        begin
            d = $urandom;
            boot({4'h7, d[2:0], 1'b1});
            op(5'h02, WA, 8'h00);
            `CHK(rdata, exp_rd(opt))
            d = $urandom;
            if (d == AC)
                d = 8'h55;
            op(5'h01, WA, d);
            wait_req(40);
            `CHK(req, 1'b1)
            @(negedge clk);
            `CHK(flag, 1'b1)
        end
        `CHK(seen, 1'b1)
        $display("test codes done");
        boot(8'h60);
        op(5'h02, WA, 8'h00);
        `CHK(rdata, exp_rd(opt))
        op(5'h01, WA, 8'h55);
        op(5'h05, WA, AC);
        op(5'h08, 16'h8000, 8'h00);
        wait_req(40);
        `CHK(req, 1'b0)
        for (int c = 0; c < 4; c++)
        begin
            boot(8'h71);
            op(c == 0 ? 5'h05 : c == 2 ? 5'h08 : 5'h10,
                c == 0 ? WA : c == 1 ? `WWD_TOP_REGION_BASE : 16'h8000, AC);
            wait_req(40);
            `CHK(req, c != 1)
        end
        $display("test access done");
        boot(8'h12);
        op(5'h01, WA, AC);
        wait_req(40);
        `CHK(req, 1'b0)
        repeat (100) @(posedge clk);
        op(5'h01, WA, AC);
        wait_req(40);
        `CHK(req, 1'b1)
        $display("test window done");
        boot(8'h71);
        wait_req(7000);
        op(5'h01, WA, AC);
        wait_req(tmo(0) - 200);
        `CHK(req, 1'b0)
        wait_req(400);
        `CHK(req, 1'b1)
        $display("test overflow done");
        boot(8'h70);
        halt <= 1'b1;
        wait_req(tmo(0) / 2 + 250);
        `CHK(req, 1'b0)
        @(posedge clk);
        halt <= 1'b0;
        stopm <= 1'b1;
        wait_req(tmo(0) / 2 + 250);
        `CHK(req, 1'b0)
        @(posedge clk);
        stopm <= 1'b0;
        wait_req(tmo(0) - 300);
        `CHK(req, 1'b0)
        wait_req(600);
        `CHK(req, 1'b1)
        $display("test halt done");
        boot(8'h70);
        ostop <= 1'b1;
        wait_req(tmo(0) + 500);
        `CHK(req, 1'b0)
        op(5'h01, WA, 8'h55);
        wait_req(100);
        `CHK(req, 1'b0)
        @(posedge clk);
        ostop <= 1'b0;
        wait_req(40);
        `CHK(req, 1'b1)
        $display("test osc stop done");
        stop_test;
    end
endmodule // windowed_watchdog_timer_tb
